// *** common/irc_map.svh ***
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH

// Register byte addresses
`define IRC_CTX_WIN 5'h08
`define IRC_CTRL_SET 5'h00
`define IRC_CTRL_CLR 5'h04
`define IRC_MATCH 5'h10
`define IRC_MASK_HI_SET 12'h070
`define IRC_MASK_HI_CLR 12'h074
`define IRC_MASK_LO_SET 12'h078
`define IRC_MASK_LO_CLR 12'h07c

// Control register bit positions
`define IRC_B_PACKED 31
`define IRC_B_HDR 30
`define IRC_B_CYCEN 29
`define IRC_B_MULTI 28
`define IRC_B_SPLIT 27
`define IRC_B_RUN 15
`define IRC_B_WAKE 12
`define IRC_B_DEAD 11
`define IRC_B_ACTIVE 10

// Match register fields
`define IRC_CMP_LSB 12
`define IRC_CHAN_LSB 0

// Speed codes
`define IRC_SPD_100 3'h0
`define IRC_SPD_200 3'h1
`define IRC_SPD_400 3'h2

// Completion codes
`define IRC_ACK_COMPLETE 5'h11
`define IRC_ACK_DATA_ERROR 5'h1d
`define IRC_EVT_LONG_PACKET 5'h02
`define IRC_EVT_OVERRUN 5'h05
`define IRC_EVT_DESC_READ 5'h06
`define IRC_EVT_DATA_WRITE 5'h08
`define IRC_EVT_UNKNOWN 5'h0e

// Reset values
`define IRC_RST_MASK 32'h0000_0000
`define IRC_RST_SPD 3'h0
`define IRC_RST_EVT 5'h00

`endif

// *** common/irc_pkg.sv ***
package irc_pkg;

  typedef enum logic [2:0] {
    ST_STOP = 3'h0,
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_ACTIVE = 3'h3,
    ST_DEAD = 3'h4
  } irc_state_e;

  typedef struct packed {
    irc_state_e [3:0] st;
    logic [3:0] run;
    logic [3:0] wake;
    logic [3:0] active;
    logic [3:0] cycEn;
    logic [3:0] multi;
    logic [3:0] packedMode;
    logic [3:0] split;
    logic [3:0] hdr;
    logic [3:0][2:0] spd;
    logic [3:0][4:0] evt;
    logic [3:0][12:0] cmp;
    logic [3:0][5:0] chan;
    logic [31:0] maskHi;
    logic [31:0] maskLo;
    logic [31:0] rdData;
  } irc_top_s;

  typedef struct packed {
    logic accept;
    logic backout;
  } irc_flt_s;

endpackage : irc_pkg

// *** core/irc_chan_filter.sv ***
`timescale 1ns/1ps
`include "irc_map.svh"

module irc_chan_filter
  import irc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic pktValid,
  input wire logic [5:0] pktChannel,
  input wire logic pktErrLen,
  input wire logic pktErrCrc,
  input wire logic pktOverrun,
  input wire logic ctxActive,
  input wire logic multiChan,
  input wire logic packedMode,
  input wire logic [5:0] matchChannel,
  input wire logic [63:0] chanMask,
  output logic accept,
  output logic backout
);

  irc_flt_s s_r;
  irc_flt_s s_nxt;
  logic hit;

  always_comb
  begin
    s_nxt = s_r;
    hit = multiChan ? chanMask[pktChannel] : (pktChannel == matchChannel);
    s_nxt.accept = pktValid & ctxActive & hit;
    s_nxt.backout = pktValid & ctxActive & hit & packedMode
                    & (pktErrLen | pktErrCrc | pktOverrun);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign accept = s_r.accept;
  assign backout = s_r.backout;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_MULTI_ACCEPT: assert property (
    (pktValid && ctxActive && multiChan) |=> (accept == $past(chanMask[pktChannel])))
    else $error("multi-channel accept does not follow the channel mask");
  AST_SINGLE_ACCEPT: assert property (
    (pktValid && ctxActive && !multiChan && pktChannel != matchChannel) |=> !accept)
    else $error("single-channel context accepted a foreign channel");
  AST_BACKOUT: assert property (
    (pktValid && ctxActive && hit && packedMode && pktErrCrc) |=> (accept && backout))
    else $error("erroneous packed packet was not backed out");

endmodule : irc_chan_filter

// *** core/iso_rx_context_control.sv ***
// How it works
// - With trigger enabled, context starts when cycle compare equals received cycle count.
// - Trigger enable clears itself once the context becomes active.
// - Multi-channel receive accepts every channel enabled in the channel mask.
// - Without multi-channel, only the match register's channel is accepted.
// - Split-payload mode streams first and second payload to separate buffers.
// - Split-payload mode forces multi-channel and packed-buffer bits to zero.
// - Split-payload bit ignores writes while active or running.
// - Reserved control bits 26-16, 14-13 and 9-8 read zero.
// - Software alone sets and clears run; device clears it only on reset.
// - Wake resumes processing; a descriptor fetch clears wake unless software sets wake in the same cycle.
// - Dead sets on fatal error and clears when run is cleared.
// - Active is high whenever the context processes descriptors.
// - Speed field codes 100, 200 and 400 Mbit/s as 000, 001, 010.
// - Packed mode completion codes limited to four values.
// - Packed mode backs out length, CRC and overrun errored packets.
// - Packet-per-buffer mode completion codes limited to seven values.
// - Packed mode fills buffers back to back, else one packet per buffer.
// - Header-keep stores header, transfer status and cycle_a, else strips header.
// - Four independent contexts, each with its own control register.
`timescale 1ns/1ps
`include "irc_map.svh"

module iso_rx_context_control
  import irc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic softRst,
  input wire logic cycStartValid,
  input wire logic [12:0] cycStartCount,
  input wire logic [3:0] descFetch,
  input wire logic [3:0] fatalErr,
  input wire logic [3:0] dmaIdle,
  input wire logic pktValid,
  input wire logic [5:0] pktChannel,
  input wire logic pktErrLen,
  input wire logic pktErrCrc,
  input wire logic pktOverrun,
  input wire logic [3:0] stsValid,
  input wire logic [2:0] stsSpeed,
  input wire logic [4:0] stsEvent,
  output logic [3:0] ctxActive,
  output logic [3:0] ctxWake,
  output logic [3:0] ctxMultiChan,
  output logic [3:0] ctxPacked,
  output logic [3:0] ctxSplit,
  output logic [3:0] ctxHeaderKeep,
  output logic [3:0] pktAccept,
  output logic [3:0] pktBackout
);

  irc_top_s s_r;
  irc_top_s s_nxt;
  logic [3:0] wrSet;
  logic [3:0] wrClr;
  logic [3:0] wrMatch;
  logic [3:0] rdCtrl;
  logic [3:0] rdMatch;
  logic inWin;

  // Set wins over clear in a set/clear register pair
  function automatic logic setClr(input logic cur, input logic setB, input logic clrB);
    setClr = setB ? 1'b1 : (clrB ? 1'b0 : cur);
  endfunction : setClr

  function automatic logic evtLegal(input logic packedMode, input logic [4:0] code);
    logic ok;
    ok = (code == `IRC_ACK_COMPLETE) || (code == `IRC_EVT_DESC_READ) ||
         (code == `IRC_EVT_DATA_WRITE) || (code == `IRC_EVT_UNKNOWN);
    if (!packedMode)
      ok = ok || (code == `IRC_ACK_DATA_ERROR) || (code == `IRC_EVT_LONG_PACKET) ||
           (code == `IRC_EVT_OVERRUN);
    evtLegal = ok;
  endfunction : evtLegal

  function automatic logic [31:0] ctrlWord(input irc_top_s s, input logic [1:0] i);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`IRC_B_PACKED] = s.packedMode[i];
    w[`IRC_B_HDR] = s.hdr[i];
    w[`IRC_B_CYCEN] = s.cycEn[i];
    w[`IRC_B_MULTI] = s.multi[i];
    w[`IRC_B_SPLIT] = s.split[i];
    w[`IRC_B_RUN] = s.run[i];
    w[`IRC_B_WAKE] = s.wake[i];
    w[`IRC_B_DEAD] = (s.st[i] == ST_DEAD);
    w[`IRC_B_ACTIVE] = s.active[i];
    w[7:5] = s.spd[i];
    w[4:0] = s.evt[i];
    ctrlWord = w;
  endfunction : ctrlWord

  assign inWin = (regAddr[11:7] == `IRC_CTX_WIN);

  // Per-context address decode and packet filter
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gCtx
      logic sel;
      assign sel = inWin && (regAddr[6:5] == 2'(g));
      assign wrSet[g] = regWr && sel && (regAddr[4:0] == `IRC_CTRL_SET);
      assign wrClr[g] = regWr && sel && (regAddr[4:0] == `IRC_CTRL_CLR);
      assign wrMatch[g] = regWr && sel && (regAddr[4:0] == `IRC_MATCH);
      assign rdCtrl[g] = regRd && sel &&
                         ((regAddr[4:0] == `IRC_CTRL_SET) || (regAddr[4:0] == `IRC_CTRL_CLR));
      assign rdMatch[g] = regRd && sel && (regAddr[4:0] == `IRC_MATCH);

      irc_chan_filter uFilter (
        .clock(clock),
        .nrst(nrst),
        .pktValid(pktValid),
        .pktChannel(pktChannel),
        .pktErrLen(pktErrLen),
        .pktErrCrc(pktErrCrc),
        .pktOverrun(pktOverrun),
        .ctxActive(s_r.active[g]),
        .multiChan(s_r.multi[g]),
        .packedMode(s_r.packedMode[g]),
        .matchChannel(s_r.chan[g]),
        .chanMask({s_r.maskHi, s_r.maskLo}),
        .accept(pktAccept[g]),
        .backout(pktBackout[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic busy;
    logic wakeSw;
    logic start;
    logic cycHit;
    busy = 1'b0;
    wakeSw = 1'b0;
    start = 1'b0;
    cycHit = 1'b0;
    s_nxt = s_r;
    s_nxt.rdData = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      busy = s_r.run[i] | s_r.active[i];
      s_nxt.packedMode[i] = setClr(s_r.packedMode[i], wrSet[i] & regWrData[`IRC_B_PACKED],
                                   wrClr[i] & regWrData[`IRC_B_PACKED]);
      s_nxt.hdr[i] = setClr(s_r.hdr[i], wrSet[i] & regWrData[`IRC_B_HDR],
                            wrClr[i] & regWrData[`IRC_B_HDR]);
      s_nxt.cycEn[i] = setClr(s_r.cycEn[i], wrSet[i] & regWrData[`IRC_B_CYCEN],
                              wrClr[i] & regWrData[`IRC_B_CYCEN]);
      s_nxt.multi[i] = setClr(s_r.multi[i], wrSet[i] & regWrData[`IRC_B_MULTI],
                              wrClr[i] & regWrData[`IRC_B_MULTI]);
      if (!busy)
        s_nxt.split[i] = setClr(s_r.split[i], wrSet[i] & regWrData[`IRC_B_SPLIT],
                                wrClr[i] & regWrData[`IRC_B_SPLIT]);
      if (s_nxt.split[i])
      begin
        s_nxt.multi[i] = 1'b0;
        s_nxt.packedMode[i] = 1'b0;
      end
      if (softRst)
        s_nxt.run[i] = 1'b0;
      else
        s_nxt.run[i] = setClr(s_r.run[i], wrSet[i] & regWrData[`IRC_B_RUN],
                              wrClr[i] & regWrData[`IRC_B_RUN]);
      // Software can only set wake; a set in the fetch cycle survives
      wakeSw = wrSet[i] & regWrData[`IRC_B_WAKE];
      s_nxt.wake[i] = wakeSw | (s_r.wake[i] & ~descFetch[i]);

      cycHit = s_r.cycEn[i] && cycStartValid && (cycStartCount == s_r.cmp[i]);
      start = 1'b0;
      case (s_r.st[i])
        ST_STOP:
        begin
          if (s_nxt.run[i])
            start = 1'b1;
        end
        ST_IDLE:
        begin
          if (s_r.wake[i])
            start = 1'b1;
        end
        ST_WAIT:
        begin
          if (cycHit)
            s_nxt.st[i] = ST_ACTIVE;
        end
        ST_ACTIVE:
        begin
          if (dmaIdle[i])
            s_nxt.st[i] = ST_IDLE;
        end
        ST_DEAD:
        begin
          s_nxt.st[i] = ST_DEAD;
        end
        default:
        begin
          s_nxt.st[i] = ST_STOP;
        end
      endcase
      if (start)
        s_nxt.st[i] = s_nxt.cycEn[i] ? ST_WAIT : ST_ACTIVE;
      if (fatalErr[i] && s_r.run[i] && s_r.st[i] != ST_STOP)
        s_nxt.st[i] = ST_DEAD;
      if (!s_nxt.run[i])
        s_nxt.st[i] = ST_STOP;
      s_nxt.active[i] = (s_nxt.st[i] == ST_ACTIVE);
      if (s_nxt.active[i])
        s_nxt.cycEn[i] = 1'b0;

      if (stsValid[i])
      begin
        s_nxt.spd[i] = stsSpeed;
        s_nxt.evt[i] = evtLegal(s_r.packedMode[i], stsEvent) ? stsEvent
                       : `IRC_EVT_UNKNOWN;
      end
      if (wrMatch[i])
      begin
        s_nxt.cmp[i] = regWrData[`IRC_CMP_LSB +: 13];
        s_nxt.chan[i] = regWrData[`IRC_CHAN_LSB +: 6];
      end
      if (rdCtrl[i])
        s_nxt.rdData = ctrlWord(s_r, i[1:0]);
      if (rdMatch[i])
        s_nxt.rdData = {7'h00, s_r.cmp[i], 6'h00, s_r.chan[i]};
    end

    if (regWr && regAddr == `IRC_MASK_HI_SET)
      s_nxt.maskHi = s_r.maskHi | regWrData;
    if (regWr && regAddr == `IRC_MASK_HI_CLR)
      s_nxt.maskHi = s_r.maskHi & ~regWrData;
    if (regWr && regAddr == `IRC_MASK_LO_SET)
      s_nxt.maskLo = s_r.maskLo | regWrData;
    if (regWr && regAddr == `IRC_MASK_LO_CLR)
      s_nxt.maskLo = s_r.maskLo & ~regWrData;
    if (regRd && (regAddr == `IRC_MASK_HI_SET || regAddr == `IRC_MASK_HI_CLR))
      s_nxt.rdData = s_r.maskHi;
    if (regRd && (regAddr == `IRC_MASK_LO_SET || regAddr == `IRC_MASK_LO_CLR))
      s_nxt.rdData = s_r.maskLo;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.st <= '{ST_STOP, ST_STOP, ST_STOP, ST_STOP};
      s_r.maskHi <= `IRC_RST_MASK;
      s_r.maskLo <= `IRC_RST_MASK;
      s_r.spd <= {`IRC_RST_SPD, `IRC_RST_SPD, `IRC_RST_SPD, `IRC_RST_SPD};
      s_r.evt <= {`IRC_RST_EVT, `IRC_RST_EVT, `IRC_RST_EVT, `IRC_RST_EVT};
    end
    else
      s_r <= s_nxt;
  end

  assign regRdData = s_r.rdData;
  assign ctxActive = s_r.active;
  assign ctxWake = s_r.wake;
  assign ctxMultiChan = s_r.multi;
  assign ctxPacked = s_r.packedMode;
  assign ctxSplit = s_r.split;
  assign ctxHeaderKeep = s_r.hdr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_RSVD_ZERO: assert property (
    (|rdCtrl) |=> (regRdData[26:16] == 11'h000 && regRdData[14:13] == 2'h0 &&
                   regRdData[9:8] == 2'h0))
    else $error("reserved control bits read non-zero");

  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gAst
      AST_SPLIT_FORCE: assert property (
        s_r.split[g] |-> (!s_r.multi[g] && !s_r.packedMode[g]))
        else $error("split mode left multi-channel or packed set");
      AST_CYCEN_CLEAR: assert property (
        $rose(s_r.active[g]) |-> !s_r.cycEn[g])
        else $error("trigger enable still set after activation");
      AST_WAKE_CLEAR: assert property (
        (descFetch[g] && !(wrSet[g] && regWrData[`IRC_B_WAKE])) |=> !s_r.wake[g])
        else $error("wake survived a descriptor fetch");
      AST_DEAD_SET: assert property (
        (fatalErr[g] && s_r.run[g] && s_r.st[g] != ST_STOP && !softRst &&
         !(wrClr[g] && regWrData[`IRC_B_RUN])) |=> (s_r.st[g] == ST_DEAD))
        else $error("fatal error did not set dead");
      AST_DEAD_CLR: assert property (
        !s_r.run[g] |-> (s_r.st[g] != ST_DEAD && !s_r.active[g]))
        else $error("dead or active while run is clear");
      AST_SPLIT_HOLD: assert property (
        (s_r.run[g] || s_r.active[g]) |=> (s_r.split[g] == $past(s_r.split[g])))
        else $error("split mode changed while busy");
      AST_CYC_START: assert property (
        (s_r.st[g] == ST_WAIT && cycStartValid && cycStartCount == s_r.cmp[g] &&
         s_r.run[g] && !fatalErr[g] && !softRst && !wrClr[g]) |=> s_r.active[g])
        else $error("cycle match did not start the context");
      AST_RUN_HW: assert property (
        (!softRst && !(wrSet[g] && regWrData[`IRC_B_RUN]) &&
         !(wrClr[g] && regWrData[`IRC_B_RUN])) |=> $stable(s_r.run[g]))
        else $error("run changed without software or reset");
      AST_ACTIVE_RUN: assert property (
        (s_r.st[g] == ST_STOP && s_nxt.run[g] && !s_nxt.cycEn[g]) |=> s_r.active[g] [*1])
        else $error("run without trigger did not activate");
      AST_STS_PAIR: assert property (
        stsValid[g] |=> (s_r.spd[g] == $past(stsSpeed) &&
                         (s_r.evt[g] == $past(stsEvent) || s_r.evt[g] == `IRC_EVT_UNKNOWN)))
        else $error("speed and completion code not updated together");
      AST_PACKED_CODE: assert property (
        (stsValid[g] && s_r.packedMode[g] && stsEvent == `IRC_EVT_OVERRUN)
        |=> (s_r.evt[g] == `IRC_EVT_UNKNOWN))
        else $error("illegal packed-mode completion code stored");
    end
  endgenerate

endmodule : iso_rx_context_control

// *** bench/irc_dma_model.sv ***
`timescale 1ns/1ps

module irc_dma_model
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] ctxActive,
  input wire logic [3:0] ctxWake,
  input wire logic [3:0] reqFetch,
  input wire logic [3:0] reqIdle,
  input wire logic [3:0] reqFatal,
  input wire logic [3:0] reqSts,
  input wire logic [7:0] reqStatus,
  output logic [3:0] descFetch,
  output logic [3:0] dmaIdle,
  output logic [3:0] fatalErr,
  output logic [3:0] stsValid,
  output logic [2:0] stsSpeed,
  output logic [4:0] stsEvent
);
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      descFetch <= 4'h0;
      dmaIdle <= 4'h0;
      fatalErr <= 4'h0;
      stsValid <= 4'h0;
      {stsSpeed, stsEvent} <= 8'h00;
    end
    else
    begin
      // Fetches only for a context that is active or has been woken
      descFetch <= reqFetch & (ctxActive | ctxWake);
      dmaIdle <= reqIdle & ctxActive;
      fatalErr <= reqFatal & ctxActive;
      stsValid <= reqSts & ctxActive;
      // Speed and code leave together; between writebacks they toggle
      {stsSpeed, stsEvent} <= (reqSts != 4'h0) ? reqStatus : ~{stsSpeed, stsEvent};
    end
  end
endmodule : irc_dma_model

// *** bench/iso_rx_context_control_test.sv ***
`timescale 1ns/1ps
`include "irc_map.svh"

module iso_rx_context_control_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic softRst = 1'b0;
  logic cycStartValid = 1'b0;
  logic [12:0] cycStartCount = 13'h0000;
  logic pktValid = 1'b0;
  logic [5:0] pktChannel = 6'h00;
  logic pktErrLen = 1'b0;
  logic pktErrCrc = 1'b0;
  logic pktOverrun = 1'b0;
  logic [3:0] reqFetch = 4'h0;
  logic [3:0] reqIdle = 4'h0;
  logic [3:0] reqFatal = 4'h0;
  logic [3:0] reqSts = 4'h0;
  logic [7:0] reqStatus = 8'h00;
  logic [3:0] descFetch, dmaIdle, fatalErr, stsValid;
  logic [2:0] stsSpeed;
  logic [4:0] stsEvent;
  logic [3:0] ctxActive, ctxWake, ctxMultiChan, ctxPacked, ctxSplit, ctxHeaderKeep;
  logic [3:0] pktAccept, pktBackout;
  logic [31:0] mCtl [4] = '{default: 32'h0000_0000};
  logic [31:0] mMat [4] = '{default: 32'h0000_0000};
  logic [63:0] mMask = 64'h0;
  logic [7:0] rnd = 8'h28;
  logic [4:0] evT [9] = '{`IRC_ACK_COMPLETE, `IRC_ACK_DATA_ERROR, `IRC_EVT_LONG_PACKET,
    `IRC_EVT_OVERRUN, `IRC_EVT_DESC_READ, `IRC_EVT_DATA_WRITE, `IRC_EVT_UNKNOWN, 5'h03, 5'h1f};
  int error_cnt = 0;
  int n_compared = 0;

  always #20 clock = ~clock;

  iso_rx_context_control i_iso_rx_context_control (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .softRst(softRst), .cycStartValid(cycStartValid),
    .cycStartCount(cycStartCount), .descFetch(descFetch), .fatalErr(fatalErr),
    .dmaIdle(dmaIdle), .pktValid(pktValid), .pktChannel(pktChannel), .pktErrLen(pktErrLen),
    .pktErrCrc(pktErrCrc), .pktOverrun(pktOverrun), .stsValid(stsValid),
    .stsSpeed(stsSpeed), .stsEvent(stsEvent), .ctxActive(ctxActive), .ctxWake(ctxWake),
    .ctxMultiChan(ctxMultiChan), .ctxPacked(ctxPacked), .ctxSplit(ctxSplit),
    .ctxHeaderKeep(ctxHeaderKeep), .pktAccept(pktAccept), .pktBackout(pktBackout));

  irc_dma_model i_irc_dma_model (.clock(clock), .nrst(nrst), .ctxActive(ctxActive),
    .ctxWake(ctxWake), .reqFetch(reqFetch), .reqIdle(reqIdle), .reqFatal(reqFatal),
    .reqSts(reqSts), .reqStatus(reqStatus), .descFetch(descFetch), .dmaIdle(dmaIdle),
    .fatalErr(fatalErr), .stsValid(stsValid), .stsSpeed(stsSpeed), .stsEvent(stsEvent));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {1'b0, s[7:1]} ^ (s[0] ? 8'hb8 : 8'h00);
  endfunction : lfsr

  function automatic logic [3:0] fl(input int b);
    for (int k = 0; k < 4; k++)
      fl[k] = mCtl[k][b];
  endfunction : fl

  function automatic logic [4:0] legal(input int c, input logic [4:0] e);
    if (e inside {`IRC_ACK_COMPLETE, `IRC_EVT_DESC_READ, `IRC_EVT_DATA_WRITE})
      return e;
    if (!mCtl[c][31] && e inside {`IRC_ACK_DATA_ERROR, `IRC_EVT_LONG_PACKET, `IRC_EVT_OVERRUN})
      return e;
    return `IRC_EVT_UNKNOWN;
  endfunction : legal

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int c;
    logic bz;
    c = a[6:5];
    bz = mCtl[c][15] | mCtl[c][10];
    if (bz && a[11:7] == `IRC_CTX_WIN)
      d[27] = 1'b0;
    if (a[11:7] == `IRC_CTX_WIN && a[4:0] == `IRC_CTRL_SET)
    begin
      if (d[15] && !bz || d[12] && mCtl[c][15] && !mCtl[c][10] && !mCtl[c][11])
        mCtl[c][10] = !(mCtl[c][29] | d[29]);
      mCtl[c] = mCtl[c] | (d & 32'hf800_9000);
      if (mCtl[c][27])
        {mCtl[c][31], mCtl[c][28]} = 2'b00;
    end
    if (a[11:7] == `IRC_CTX_WIN && a[4:0] == `IRC_CTRL_CLR)
    begin
      mCtl[c] = mCtl[c] & ~(d & 32'hf800_8000);
      if (d[15])
        mCtl[c][11:10] = 2'b00;
    end
    if (a[11:7] == `IRC_CTX_WIN && a[4:0] == `IRC_MATCH)
      mMat[c] = d & 32'h01ff_f03f;
    if (a == `IRC_MASK_HI_SET) mMask[63:32] |= d;
    if (a == `IRC_MASK_HI_CLR) mMask[63:32] &= ~d;
    if (a == `IRC_MASK_LO_SET) mMask[31:0] |= d;
    if (a == `IRC_MASK_LO_CLR) mMask[31:0] &= ~d;
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic [31:0] e;
    e = 32'h0;
    if (a[11:7] == `IRC_CTX_WIN && (a[4:0] == `IRC_CTRL_SET || a[4:0] == `IRC_CTRL_CLR))
      e = mCtl[a[6:5]];
    if (a[11:7] == `IRC_CTX_WIN && a[4:0] == `IRC_MATCH)
      e = mMat[a[6:5]];
    if (a[11:4] == 8'h07)
      e = a[3] ? mMask[31:0] : mMask[63:32];
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    chk("regRdData", e, regRdData);
    chk("ctxModes", {8'h0, fl(10), fl(12), fl(28), fl(31), fl(27), fl(30)},
      {8'h0, ctxActive, ctxWake, ctxMultiChan, ctxPacked, ctxSplit, ctxHeaderKeep});
    @(posedge clock);
  endtask : rd

  task automatic pkt(input logic [5:0] ch, input logic [2:0] er);
    logic [3:0] ea;
    logic [3:0] eb;
    for (int c = 0; c < 4; c++)
    begin
      ea[c] = mCtl[c][10] & (mCtl[c][28] ? mMask[ch] : ch == mMat[c][5:0]);
      eb[c] = ea[c] & mCtl[c][31] & |er;
    end
    pktValid <= 1'b1;
    pktChannel <= ch;
    {pktErrLen, pktErrCrc, pktOverrun} <= er;
    @(posedge clock);
    pktValid <= 1'b0;
    @(negedge clock);
    chk("pktFilter", {24'h0, ea, eb}, {24'h0, pktAccept, pktBackout});
    @(posedge clock);
  endtask : pkt

  task automatic cyc(input logic [12:0] n);
    cycStartValid <= 1'b1;
    cycStartCount <= n;
    @(posedge clock);
    cycStartValid <= 1'b0;
    cycStartCount <= ~n;
    @(posedge clock);
    for (int c = 0; c < 4; c++)
      if (mCtl[c][15] && mCtl[c][29] && !mCtl[c][10] && !mCtl[c][11] && n == mMat[c][24:12])
      begin
        mCtl[c][29] = 1'b0;
        mCtl[c][10] = 1'b1;
      end
  endtask : cyc

  task automatic dma(input logic [3:0] f, i, x, s, input logic [7:0] st);
    {reqFetch, reqIdle, reqFatal, reqSts, reqStatus} <= {f, i, x, s, st};
    @(posedge clock);
    {reqFetch, reqIdle, reqFatal, reqSts} <= 16'h0;
    @(posedge clock);
    for (int k = 0; k < 4; k++)
    begin
      if (f[k]) mCtl[k][12] = 1'b0;
      if (i[k]) mCtl[k][10] = 1'b0;
      if (x[k]) mCtl[k][11:10] = 2'b10;
      if (s[k]) mCtl[k][7:0] = {st[7:5], legal(k, st[4:0])};
    end
  endtask : dma

  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    test_done();
  end

  initial
  begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(12'h400);
    rd(12'h800);
    $display("test reset done");
    wr(12'h420, 32'hffff_6fff);
    rd(12'h424);
    wr(12'h424, 32'hffff_ffff);
    wr(12'h420, 32'h0000_8000);
    wr(12'h420, 32'h0800_0000);
    rd(12'h420);
    wr(12'h424, 32'h0000_8000);
    rd(12'h420);
    $display("test fields done");
    wr(12'h410, {7'h7f, 13'h1abc, 6'h3f, 6'h05});
    rd(12'h410);
    wr(12'h400, 32'h2000_8000);
    rd(12'h400);
    cyc(13'h1abb);
    rd(12'h400);
    cyc(13'h1abc);
    rd(12'h400);
    $display("test trigger done");
    wr(`IRC_MASK_LO_SET, 32'h0000_0080);
    wr(`IRC_MASK_HI_SET, 32'h8000_0000);
    wr(12'h440, 32'h9000_0000);
    wr(12'h440, 32'h0000_8000);
    pkt(6'd7, 3'b010);
    pkt(6'd63, 3'b001);
    pkt(6'd5, 3'b100);
    pkt(6'd6, 3'b000);
    wr(`IRC_MASK_LO_CLR, 32'h0000_0080);
    pkt(6'd7, 3'b000);
    rd(`IRC_MASK_LO_CLR);
    $display("test filter done");
    for (int k = 0; k < 9; k++)
    begin
      rnd = lfsr(rnd);
      dma(4'h0, 4'h0, 4'h0, 4'h5, {3'(rnd % 3), evT[k]});
      rd(12'h400);
      rd(12'h440);
    end
    $display("test status done");
    dma(4'h0, 4'h1, 4'h0, 4'h0, 8'h00);
    rd(12'h400);
    wr(12'h400, 32'h0000_1000);
    rd(12'h400);
    dma(4'h1, 4'h0, 4'h0, 4'h0, 8'h00);
    rd(12'h404);
    $display("test wake done");
    dma(4'h0, 4'h0, 4'h1, 4'h0, 8'h00);
    rd(12'h400);
    wr(12'h404, 32'h0000_8000);
    rd(12'h400);
    softRst <= 1'b1;
    @(posedge clock);
    softRst <= 1'b0;
    @(posedge clock);
    for (int c = 0; c < 4; c++)
      mCtl[c][15:10] = 6'h00;
    rd(12'h440);
    $display("test dead and soft reset done");
    test_done();
  end
endmodule : iso_rx_context_control_test
